// ==== inc/dcc_pkg.sv ====
// Purpose: shared constants and types of the dac control and clear-code register bank
// Assumes: 24-bit serial frames, 20-bit register data
// Notes: field positions follow the mode control register layout
package dcc_pkg;

  localparam int DCC_FRAME_BITS = 24;
  localparam int DCC_DATA_W = 20;
  localparam int DCC_CNT_W = 5;

  localparam logic [DCC_CNT_W-1:0] DCC_CNT_FULL = 5'h18;
  localparam logic [DCC_CNT_W-1:0] DCC_CNT_OVER = 5'h19;

  localparam int DCC_RW_BIT = 23;
  localparam int DCC_ADDR_HI = 22;
  localparam int DCC_ADDR_LO = 20;

  localparam logic [2:0] DCC_ADDR_NOP = 3'h0;
  localparam logic [2:0] DCC_ADDR_DAC = 3'h1;
  localparam logic [2:0] DCC_ADDR_MODE = 3'h2;
  localparam logic [2:0] DCC_ADDR_CLEAR = 3'h3;
  localparam logic [2:0] DCC_ADDR_SWCTL = 3'h4;

  // mode control field positions
  localparam int DCC_BIT_AMP_FB = 1;
  localparam int DCC_BIT_GND_CLAMP = 2;
  localparam int DCC_BIT_CORE_FLOAT = 3;
  localparam int DCC_BIT_CODE_FMT = 4;
  localparam int DCC_BIT_RD_DIS = 5;

  // software control field positions
  localparam int DCC_BIT_SW_LOAD = 0;
  localparam int DCC_BIT_SW_CLEAR = 1;
  localparam int DCC_BIT_SW_RESET = 2;

  localparam logic [DCC_DATA_W-1:0] DCC_CLEAR_RST = 20'h00000;
  localparam logic [DCC_DATA_W-1:0] DCC_DAC_RST = 20'h00000;

  typedef struct packed {
    logic readout_pin_disable;
    logic code_format_select;
    logic core_float_control;
    logic output_ground_clamp;
    logic amp_feedback_select;
  } dcc_ctrl_t;

  localparam dcc_ctrl_t DCC_CTRL_RST = '{
    readout_pin_disable: 1'b0,
    code_format_select: 1'b0,
    core_float_control: 1'b1,
    output_ground_clamp: 1'b1,
    amp_feedback_select: 1'b1
  };

  typedef enum logic [1:0] {
    DCC_OST_NORMAL,
    DCC_OST_CLAMPED,
    DCC_OST_HIGHZ
  } dcc_ostate_t;

endpackage

// ==== testbench/dcc_host.sv ====
// Purpose: serial host that sends frames and captures readout
// Assumes: clk runs far faster than the link clock
// Notes: link clock idles high and stands still between frames
`timescale 1ns/100ps
module dcc_host (
  input wire logic clk,
  input wire logic ro,
  input wire logic ro_oe,
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  logic last = 1'b0;
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  // n falling edges; an undriven readout pin reads as the inverse of the last bit
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    sync_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int k = 0; k < n; k++) begin
      sdin = (k < 24) ? w[23 - k] : 1'b0;
      repeat (4) @(negedge clk);
      last = ro_oe ? ro : ~last;
      if (k < 24) r[23 - k] = last;
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
    end
    repeat (4) @(negedge clk);
    sync_n = 1'b1;
    sdin = ~sdin;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ==== testbench/dcc_regs_sva.sv ====
// Purpose: concurrent checks on the register bank outputs
// Assumes: one clock domain
// Notes: output decode is checked once mode has settled
`timescale 1ns/100ps
module dcc_regs_sva
  import dcc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sync_n,
  input wire logic clear_request_n,
  input wire logic serial_readout_pin_oe,
  input wire dcc_ctrl_t mode,
  input wire logic [DCC_DATA_W-1:0] clear_value,
  input wire logic [DCC_DATA_W-1:0] dac_value,
  input wire logic [DCC_DATA_W-1:0] converter_code,
  input wire dcc_ostate_t output_state,
  input wire logic amp_powered,
  input wire logic feedback_series
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  amp_power_a: assert property (amp_powered != mode.amp_feedback_select)
    else $error("amp power wrong");
  fb_series_a: assert property (feedback_series != mode.amp_feedback_select)
    else $error("feedback wiring wrong");
  clamp_state_a: assert property (mode.output_ground_clamp && $stable(mode) |-> output_state == DCC_OST_CLAMPED)
    else $error("clamp not applied");
  normal_state_a: assert property (!mode.output_ground_clamp && !mode.core_float_control && $stable(mode)
    |-> output_state == DCC_OST_NORMAL) else $error("normal state wrong");
  float_state_a: assert property (!mode.output_ground_clamp && mode.core_float_control && $stable(mode)
    |-> output_state == DCC_OST_HIGHZ) else $error("float state wrong");
  code_fmt_a: assert property ($past(rstn) && $stable(mode) && $stable(dac_value)
    |-> converter_code == {dac_value[19] ^ !mode.code_format_select, dac_value[18:0]})
    else $error("code format wrong");
  clear_load_a: assert property (!clear_request_n [*4] |-> dac_value == clear_value)
    else $error("clear value not loaded");
  ro_idle_a: assert property (sync_n [*5] |-> !serial_readout_pin_oe)
    else $error("readout driven outside frame");
  ro_dis_a: assert property (mode.readout_pin_disable |-> !serial_readout_pin_oe)
    else $error("readout driven while disabled");
endmodule
bind dcc_regs dcc_regs_sva chk (.clk, .rstn, .sync_n, .clear_request_n, .serial_readout_pin_oe, .mode,
  .clear_value, .dac_value, .converter_code, .output_state, .amp_powered, .feedback_series);

// ==== testbench/dcc_regs_tb_top.sv ====
// Purpose: directed test of the mode and clear-code registers
// Assumes: link clock 320 ns, system clock 40 ns
// Notes: load pin is held high throughout
`timescale 1ns/100ps
module dcc_regs_tb_top
  import dcc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clr_n = 1'b1;
  logic load_strobe_n_n = 1'b1;
  logic sclk, sync_n, sdin, ro, ro_oe, amp, ser;
  dcc_ctrl_t mode;
  dcc_ostate_t ost;
  logic [19:0] clear_value, dac_value, code;
  logic [23:0] rd;
  int fails = 0;
  int num_checks = 0;
  initial forever #20 clk = ~clk;
  dcc_regs uut (.clk(clk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .clear_request_n(clr_n), .load_strobe_n(load_strobe_n_n), .serial_readout_pin_o(ro), .serial_readout_pin_oe(ro_oe),
    .mode(mode), .clear_value(clear_value), .dac_value(dac_value), .converter_code(code),
    .output_state(ost), .amp_powered(amp), .feedback_series(ser));
  dcc_host host (.clk(clk), .ro(ro), .ro_oe(ro_oe), .sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [23:0] w, input int n = 24);
    logic [23:0] r;
    host.xfer(w, n, r);
  endtask
  // address frame, then a no-op frame that clocks the word out
  task automatic rdreg(input logic [2:0] a, output logic [23:0] r);
    host.xfer({1'b1, a, 20'h00000}, 24, r);
    host.xfer(24'h000000, 24, r);
  endtask
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk(24'(mode), 24'h000007);
    chk(24'(ost), 24'(DCC_OST_CLAMPED));
    chk(24'(clear_value), 24'h000000);
    chk({22'h0, amp, ser}, 24'h000000);
    wr(24'h20001e, 23);
    wr(24'h20001e, 25);
    chk(24'(mode), 24'h000007);
    wr(24'h200000);
    chk(24'(ost), 24'(DCC_OST_NORMAL));
    chk({22'h0, amp, ser}, 24'h000003);
    wr(24'h200008);
    chk(24'(ost), 24'(DCC_OST_HIGHZ));
    wr(24'h20000c);
    chk(24'(ost), 24'(DCC_OST_CLAMPED));
    wr(24'h200012);
    chk(24'(mode), 24'h000009);
    rdreg(3'h2, rd);
    chk(rd, 24'ha00012);
    wr(24'h312345);
    chk(24'(clear_value), 24'h012345);
    clr_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(24'(dac_value), 24'h012345);
    chk(24'(code), 24'h012345);
    wr(24'h200000);
    chk(24'(code), 24'h092345);
    clr_n = 1'b1;
    rdreg(3'h3, rd);
    chk(rd, 24'hb12345);
    // dac write waits for the software load, then software clear restores the clear code
    wr(24'h1abcde);
    wr(24'h400001);
    chk(24'(dac_value), 24'h0abcde);
    chk(24'(code), 24'h02bcde);
    wr(24'h400002);
    chk(24'(dac_value), 24'h012345);
    wr(24'h200020);
    rdreg(3'h2, rd);
    chk(24'(mode), 24'h000010);
    // undriven pin reads back as the host model's alternating pattern
    chk(rd, 24'haaaaaa);
    wr(24'h400004);
    chk(24'(mode), 24'h000007);
    chk(24'(clear_value), 24'h000000);
    rdreg(3'h2, rd);
    chk(rd, 24'ha0000e);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule

// ==== verilog/dcc_regs.sv ====
// Purpose: mode control and clear-code register bank behind a 24-bit serial link
// Assumes: link pins are sampled by clk, which runs far faster than the link clock
// Notes: readout pin is given as data and output enable
`timescale 1ns/100ps

// Function
// - frame top bit zero writes, one reads
// - address 010 stores frame data into mode
// - feedback bit one: amp off, resistors parallel
// - feedback bit zero: amp on, resistors series
// - clamp bit one clamps output, core floats
// - clamp bit zero removes the ground clamp
// - clamp bit overrides the float bit
// - reset returns output to clamp mode
// - float bit defaults one, zero means normal
// - format defaults twos complement, one offset binary
// - readout disable defaults zero, one floats pin
// - clear value loaded on pin, or on software clear while the load pin is high
// - clear value uses current code format
// - clear value resets to zero
// - only 24-edge frames latch on frame end
// - read data shifts out next frame; pin is driven while sync_n is low unless readout disable is one, and floats between frames
// - clear pin loads clear value into dac
// - float and clamp bits pick output state
module dcc_regs
  import dcc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic clear_request_n,
  input wire logic load_strobe_n,
  output logic serial_readout_pin_o,
  output logic serial_readout_pin_oe,
  output dcc_ctrl_t mode,
  output logic [DCC_DATA_W-1:0] clear_value,
  output logic [DCC_DATA_W-1:0] dac_value,
  output logic [DCC_DATA_W-1:0] converter_code,
  output dcc_ostate_t output_state,
  output logic amp_powered,
  output logic feedback_series
);

  typedef struct packed {
    logic sclk_d;
    logic sync_d;
    logic load_strobe_n_d;
    logic [DCC_FRAME_BITS-1:0] shift;
    logic [DCC_CNT_W-1:0] cnt;
    logic [DCC_FRAME_BITS-1:0] out_shift;
    logic serial_readout_pin;
    logic sdo_oe;
    dcc_ctrl_t ctrl;
    logic [DCC_DATA_W-1:0] clear_code;
    logic [DCC_DATA_W-1:0] dac_reg;
    logic [DCC_DATA_W-1:0] dac_out;
    logic [DCC_DATA_W-1:0] level;
    dcc_ostate_t ostate;
    logic amp_on;
    logic fb_series;
  } dcc_state_t;

  localparam dcc_state_t ST_RST = '{
    sclk_d: 1'b1,
    sync_d: 1'b1,
    load_strobe_n_d: 1'b1,
    ctrl: DCC_CTRL_RST,
    clear_code: DCC_CLEAR_RST,
    dac_reg: DCC_DAC_RST,
    dac_out: DCC_DAC_RST,
    ostate: DCC_OST_CLAMPED,
    default: '0
  };

  logic [4:0] pins_s;
  logic sclk_s;
  logic sync_s;
  logic sdin_s;
  logic clr_s;
  logic load_strobe_n_s;
  dcc_state_t s_q;
  dcc_state_t s_d;

  dcc_sync #(
    .W(5),
    .RST_VAL(5'h1b)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({sclk, sync_n, sdin, clear_request_n, load_strobe_n}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[4];
  assign sync_s = pins_s[3];
  assign sdin_s = pins_s[2];
  assign clr_s = pins_s[1];
  assign load_strobe_n_s = pins_s[0];

  function automatic logic [DCC_DATA_W-1:0] mode_word(input dcc_ctrl_t c);
    logic [DCC_DATA_W-1:0] w;
    w = '0;
    w[DCC_BIT_AMP_FB] = c.amp_feedback_select;
    w[DCC_BIT_GND_CLAMP] = c.output_ground_clamp;
    w[DCC_BIT_CORE_FLOAT] = c.core_float_control;
    w[DCC_BIT_CODE_FMT] = c.code_format_select;
    w[DCC_BIT_RD_DIS] = c.readout_pin_disable;
    return w;
  endfunction

  function automatic dcc_ostate_t pick_state(input dcc_ctrl_t c);
    if (c.output_ground_clamp) begin
      return DCC_OST_CLAMPED;
    end else if (c.core_float_control) begin
      return DCC_OST_HIGHZ;
    end
    return DCC_OST_NORMAL;
  endfunction

  always_comb begin
    logic sclk_fall;
    logic sync_rise;
    logic rw;
    logic [2:0] addr;
    logic [DCC_DATA_W-1:0] data;
    logic [DCC_DATA_W-1:0] rdata;
    logic sw_reset;
    s_d = s_q;
    sclk_fall = s_q.sclk_d & ~sclk_s;
    sync_rise = ~s_q.sync_d & sync_s;
    rw = s_q.shift[DCC_RW_BIT];
    addr = s_q.shift[DCC_ADDR_HI:DCC_ADDR_LO];
    data = s_q.shift[DCC_DATA_W-1:0];
    rdata = '0;
    sw_reset = 1'b0;
    s_d.sclk_d = sclk_s;
    s_d.sync_d = sync_s;
    s_d.load_strobe_n_d = load_strobe_n_s;

    if (s_q.sync_d && !sync_s) begin
      s_d.cnt = '0;
    end
    if (!sync_s && sclk_fall) begin
      s_d.shift = {s_q.shift[DCC_FRAME_BITS-2:0], sdin_s};
      s_d.out_shift = {s_q.out_shift[DCC_FRAME_BITS-2:0], 1'b0};
      if (s_q.cnt != DCC_CNT_OVER) begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end

    if (sync_rise && s_q.cnt == DCC_CNT_FULL) begin
      s_d.out_shift = '0;
      if (rw) begin
        unique case (addr)
          DCC_ADDR_DAC: rdata = s_q.dac_reg;
          DCC_ADDR_MODE: rdata = mode_word(s_q.ctrl);
          DCC_ADDR_CLEAR: rdata = s_q.clear_code;
          default: rdata = '0;
        endcase
        if (addr != DCC_ADDR_NOP) begin
          s_d.out_shift = {s_q.shift[DCC_RW_BIT:DCC_ADDR_LO], rdata};
        end
      end else begin
        unique case (addr)
          DCC_ADDR_DAC: begin
            if (clr_s) begin
              s_d.dac_reg = data;
              if (!load_strobe_n_s) begin
                s_d.dac_out = data;
              end
            end
          end
          DCC_ADDR_MODE: begin
            s_d.ctrl.amp_feedback_select = data[DCC_BIT_AMP_FB];
            s_d.ctrl.output_ground_clamp = data[DCC_BIT_GND_CLAMP];
            s_d.ctrl.core_float_control = data[DCC_BIT_CORE_FLOAT];
            s_d.ctrl.code_format_select = data[DCC_BIT_CODE_FMT];
            s_d.ctrl.readout_pin_disable = data[DCC_BIT_RD_DIS];
          end
          DCC_ADDR_CLEAR: s_d.clear_code = data;
          DCC_ADDR_SWCTL: begin
            sw_reset = data[DCC_BIT_SW_RESET];
            if (data[DCC_BIT_SW_CLEAR] && load_strobe_n_s) begin
              s_d.dac_reg = s_q.clear_code;
              s_d.dac_out = s_q.clear_code;
            end else if (data[DCC_BIT_SW_LOAD] && clr_s) begin
              s_d.dac_out = s_d.dac_reg;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (s_q.load_strobe_n_d && !load_strobe_n_s && clr_s) begin
      s_d.dac_out = s_d.dac_reg;
    end
    if (!clr_s) begin
      s_d.dac_reg = s_d.clear_code;
      s_d.dac_out = s_d.clear_code;
    end

    if (sw_reset) begin
      s_d = ST_RST;
      s_d.sclk_d = sclk_s;
      s_d.sync_d = sync_s;
      s_d.load_strobe_n_d = load_strobe_n_s;
    end

    // converter sees offset binary; twos complement flips the sign bit
    s_d.level = s_d.ctrl.code_format_select ? s_d.dac_out :
                {~s_d.dac_out[DCC_DATA_W-1], s_d.dac_out[DCC_DATA_W-2:0]};
    s_d.ostate = pick_state(s_d.ctrl);
    s_d.amp_on = ~s_d.ctrl.amp_feedback_select;
    s_d.fb_series = ~s_d.ctrl.amp_feedback_select;
    s_d.serial_readout_pin = s_d.out_shift[DCC_FRAME_BITS-1];
    s_d.sdo_oe = ~sync_s & ~s_d.ctrl.readout_pin_disable;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_readout_pin_o = s_q.serial_readout_pin;
  assign serial_readout_pin_oe = s_q.sdo_oe;
  assign mode = s_q.ctrl;
  assign clear_value = s_q.clear_code;
  assign dac_value = s_q.dac_out;
  assign converter_code = s_q.level;
  assign output_state = s_q.ostate;
  assign amp_powered = s_q.amp_on;
  assign feedback_series = s_q.fb_series;

endmodule

// ==== verilog/dcc_sync.sv ====
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module dcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
